// file: design/hbap_cfg.svh
// constants for the host bus access port: addresses, spacings, widths
`ifndef HBAP_CFG_SVH
`define HBAP_CFG_SVH

`define HBAP_ADDR_W        3
`define HBAP_DATA_W        8
`define HBAP_ADDR_PTR_HI   3'h2
`define HBAP_ADDR_PTR_LO   3'h3
`define HBAP_ADDR_DATA     3'h4
`define HBAP_LEAD_TARB     4'h4
`define HBAP_PTRLO_TARB    4'h4
`define HBAP_DATA_TARB     4'h5
`define HBAP_GAP_TARB      4'h8
`define HBAP_STROBE_CYC    5'h06
`define HBAP_CNT_MAX       5'h1F

`endif

// file: design/hbap_pkg.sv
// shared types and helpers of the host bus access port
package hbap_pkg;

	// device end states, one-hot
	typedef enum logic [5:0] {
		HBAP_D_IDLE   = 6'h01,
		HBAP_D_RD_REQ = 6'h02,
		HBAP_D_RD_DLY = 6'h04,
		HBAP_D_RD_DRV = 6'h08,
		HBAP_D_WR     = 6'h10,
		HBAP_D_REFUSE = 6'h20
	} hbap_dev_state_type;

	// host end states, one-hot
	typedef enum logic [4:0] {
		HBAP_H_IDLE   = 5'h01,
		HBAP_H_ADDR   = 5'h02,
		HBAP_H_SETUP  = 5'h04,
		HBAP_H_STROBE = 5'h08,
		HBAP_H_GAP    = 5'h10
	} hbap_host_state_type;

	// arbitration periods to clock cycles: one or two cycles each
	function automatic logic [4:0] hbap_tarb_cycles(
		input logic [3:0] n,
		input logic       slow
	);
		return slow ? {n, 1'b0} : {1'b0, n};
	endfunction

endpackage

// file: design/hbap_bus_if.sv
// parallel bus between host and device ends
`timescale 1ns/100ps
`default_nettype none
interface hbap_bus_if #(
	parameter int AW = 3,
	parameter int DW = 8
);
	logic          ale;
	logic          chip_select_n;
	logic          data_strobe_n;
	logic          read_strobe_n;
	logic          write_strobe_n;
	logic          direction;
	logic          bus_timing_select_pin;
	logic [AW-1:0] addr;
	logic [DW-1:0] host_data_o;
	logic          host_data_oe;
	logic [DW-1:0] dev_data_o;
	logic          dev_data_oe;
	logic [DW-1:0] data_bus;

	// resolved data lines, pulled high when nobody drives
	assign data_bus = dev_data_oe ? dev_data_o :
		(host_data_oe ? host_data_o : '1);

	modport device (
		input  ale, chip_select_n, data_strobe_n, read_strobe_n,
		input  write_strobe_n, direction, bus_timing_select_pin, addr,
		input  data_bus,
		output dev_data_o, dev_data_oe
	);

	modport host (
		output ale, chip_select_n, data_strobe_n, read_strobe_n,
		output write_strobe_n, direction, bus_timing_select_pin, addr,
		output host_data_o, host_data_oe,
		input  data_bus
	);
endinterface
`default_nettype wire

// file: design/hbap_device.sv
// device end: strobe decode, spacing check and register access port
//
// Notes on behaviour
// - host spaces strobe leading edges four periods
// - arbitration period is one or two clocks
// - data strobe: pointer read five after data
// - pointer read after data read: five periods
// - pointer read after data write: five periods
// - after low pointer write wait four periods
// - data strobe: low pointer write five after
// - low pointer write after data write: five
// - low pointer write after data read: five
// - first read timing needs bit low, pin high
// - write behaviour ignores the timing selection
// - multiplexed address latched at strobe falling
// - direction level picks read or write
// - data driven only while read strobe active; the device keeps driving two clocks past the strobe end
// - host assumes doubled back-to-back cycle time
`timescale 1ns/100ps
`default_nettype none
`include "hbap_cfg.svh"
module hbap_device #(
	parameter int AW = `HBAP_ADDR_W,
	parameter int DW = `HBAP_DATA_W
) (
	input  wire logic          clock,
	input  wire logic          rst_n,
	input  wire logic          clk_en,
	hbap_bus_if.device         bus,
	input  wire logic          mux_mode,
	input  wire logic          ds_style,
	input  wire logic          slow_arbitration,
	input  wire logic          bus_timing_select_bit,
	input  wire logic [DW-1:0] acc_rdata,
	output logic               acc_req,
	output logic               acc_write,
	output logic [AW-1:0]      acc_addr,
	output logic [DW-1:0]      acc_wdata,
	output logic               spacing_fault,
	output logic               timing_case_one
);

	////////////////////////////////////////////////////////////////////
	// state record

	typedef struct packed {
		hbap_pkg::hbap_dev_state_type st;
		logic          s_ale;
		logic          s_cs_n;
		logic          s_ds_n;
		logic          s_rd_n;
		logic          s_wr_n;
		logic          s_dir;
		logic [AW-1:0] s_addr;
		logic [DW-1:0] s_data;
		logic          act_p;
		logic          ale_p;
		logic [AW-1:0] lat_addr;
		logic          lat_cs_n;
		logic [4:0]    lead_cnt;
		logic [4:0]    trail_cnt;
		logic          last_data;
		logic          last_ptrlo_wr;
		logic          req;
		logic          wr;
		logic [AW-1:0] a_addr;
		logic [DW-1:0] wdata;
		logic [DW-1:0] dout;
		logic          oe;
		logic          fault;
		logic          case1;
	} hbap_dev_rec_type;

	hbap_dev_rec_type s_q;
	hbap_dev_rec_type s_d;

	////////////////////////////////////////////////////////////////////
	// decode of the sampled pins

	logic          is_write;
	logic [AW-1:0] addr_now;
	logic          cs_now_n;
	logic          lead;
	logic          trail;
	logic          is_ptr;
	logic          viol;
	logic [4:0]    need_lead;
	logic [4:0]    need_ptrlo;
	logic [4:0]    need_data;

	// one strobe in data-strobe style, two in read/write style
	assign is_write = ds_style ? ~s_q.s_dir : ~s_q.s_wr_n;
	assign addr_now = mux_mode ? s_q.lat_addr : s_q.s_addr;
	assign cs_now_n = mux_mode ? s_q.lat_cs_n : s_q.s_cs_n;
	assign is_ptr = (addr_now == `HBAP_ADDR_PTR_HI) ||
		(addr_now == `HBAP_ADDR_PTR_LO);

	logic strobe_on;
	assign strobe_on = ds_style ? ~s_q.s_ds_n :
		(~s_q.s_rd_n | ~s_q.s_wr_n);
	assign lead  = strobe_on & ~s_q.act_p & ~cs_now_n;
	assign trail = ~strobe_on & s_q.act_p;

	// spacing limits in clock cycles
	assign need_lead  = hbap_pkg::hbap_tarb_cycles(`HBAP_LEAD_TARB,
		slow_arbitration);
	assign need_ptrlo = hbap_pkg::hbap_tarb_cycles(`HBAP_PTRLO_TARB,
		slow_arbitration);
	assign need_data  = hbap_pkg::hbap_tarb_cycles(`HBAP_DATA_TARB,
		slow_arbitration);

	// an access that comes too early is refused
	always_comb begin
		viol = 1'b0;
		if (s_q.lead_cnt < need_lead)
			viol = 1'b1;
		if (s_q.last_ptrlo_wr && (s_q.trail_cnt < need_ptrlo))
			viol = 1'b1;
		if (s_q.last_data && (s_q.trail_cnt < need_data) &&
			((is_ptr && !is_write) ||
			(is_write && addr_now == `HBAP_ADDR_PTR_LO)))
			viol = 1'b1;
	end

	////////////////////////////////////////////////////////////////////
	// next state

	always_comb begin
		s_d = s_q;
		// pins taken as synchronous, registered once
		s_d.s_ale  = bus.ale;
		s_d.s_cs_n = bus.chip_select_n;
		s_d.s_ds_n = bus.data_strobe_n;
		s_d.s_rd_n = bus.read_strobe_n;
		s_d.s_wr_n = bus.write_strobe_n;
		s_d.s_dir  = bus.direction;
		s_d.s_addr = bus.addr;
		s_d.s_data = bus.data_bus;
		s_d.act_p  = strobe_on;
		s_d.ale_p  = s_q.s_ale;
		s_d.req    = 1'b0;
		s_d.case1  = ~bus_timing_select_bit & bus.bus_timing_select_pin;

		// saturating spacing counters
		if (s_q.lead_cnt != `HBAP_CNT_MAX)
			s_d.lead_cnt = s_q.lead_cnt + 5'h01;
		if (s_q.trail_cnt != `HBAP_CNT_MAX)
			s_d.trail_cnt = s_q.trail_cnt + 5'h01;

		// address and select caught as the latch strobe falls
		if (mux_mode && s_q.ale_p && !s_q.s_ale) begin
			s_d.lat_addr = s_q.s_data[AW-1:0];
			s_d.lat_cs_n = s_q.s_cs_n;
		end

		case (s_q.st)
			hbap_pkg::HBAP_D_IDLE: begin
				if (lead && viol) begin
					s_d.fault = 1'b1;
					s_d.st = hbap_pkg::HBAP_D_REFUSE;
				end else if (lead) begin
					s_d.lead_cnt = 5'h00;
					s_d.a_addr = addr_now;
					s_d.last_data = (addr_now == `HBAP_ADDR_DATA);
					s_d.last_ptrlo_wr = is_write &&
						(addr_now == `HBAP_ADDR_PTR_LO);
					if (is_write) begin
						s_d.st = hbap_pkg::HBAP_D_WR;
					end else begin
						s_d.req = 1'b1;
						s_d.wr = 1'b0;
						s_d.st = hbap_pkg::HBAP_D_RD_REQ;
					end
				end
			end
			hbap_pkg::HBAP_D_RD_REQ: begin
				s_d.dout = acc_rdata;
				if (trail) begin
					s_d.trail_cnt = 5'h00;
					s_d.st = hbap_pkg::HBAP_D_IDLE;
				end else if (s_q.case1) begin
					s_d.oe = 1'b1;
					s_d.st = hbap_pkg::HBAP_D_RD_DRV;
				end else begin
					s_d.st = hbap_pkg::HBAP_D_RD_DLY;
				end
			end
			hbap_pkg::HBAP_D_RD_DLY: begin
				if (trail) begin
					s_d.trail_cnt = 5'h00;
					s_d.st = hbap_pkg::HBAP_D_IDLE;
				end else begin
					s_d.oe = 1'b1;
					s_d.st = hbap_pkg::HBAP_D_RD_DRV;
				end
			end
			hbap_pkg::HBAP_D_RD_DRV: begin
				if (trail) begin
					s_d.oe = 1'b0;
					s_d.trail_cnt = 5'h00;
					s_d.st = hbap_pkg::HBAP_D_IDLE;
				end
			end
			hbap_pkg::HBAP_D_WR: begin
				// write path is the same in both timing cases
				if (trail) begin
					s_d.req = 1'b1;
					s_d.wr = 1'b1;
					s_d.trail_cnt = 5'h00;
					s_d.st = hbap_pkg::HBAP_D_IDLE;
				end else begin
					s_d.wdata = s_q.s_data;
				end
			end
			hbap_pkg::HBAP_D_REFUSE: begin
				if (trail)
					s_d.st = hbap_pkg::HBAP_D_IDLE;
			end
			default: begin
				s_d.oe = 1'b0;
				s_d.st = hbap_pkg::HBAP_D_IDLE;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////
	// state register, frozen while the clock enable is low

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			s_q <= '0;
			s_q.st <= hbap_pkg::HBAP_D_IDLE;
			s_q.s_cs_n <= 1'b1;
			s_q.s_ds_n <= 1'b1;
			s_q.s_rd_n <= 1'b1;
			s_q.s_wr_n <= 1'b1;
			s_q.lat_cs_n <= 1'b1;
			s_q.lead_cnt <= `HBAP_CNT_MAX;
			s_q.trail_cnt <= `HBAP_CNT_MAX;
		end else if (clk_en) begin
			s_q <= s_d;
		end
	end

	////////////////////////////////////////////////////////////////////
	// outputs straight from the state record

	assign bus.dev_data_o  = s_q.dout;
	assign bus.dev_data_oe = s_q.oe;
	assign acc_req         = s_q.req;
	assign acc_write       = s_q.wr;
	assign acc_addr        = s_q.a_addr;
	assign acc_wdata       = s_q.wdata;
	assign spacing_fault   = s_q.fault;
	assign timing_case_one = s_q.case1;

endmodule // hbap_device
`default_nettype wire

// file: design/hbap_host.sv
// host end: turns user commands into spaced strobe cycles
`timescale 1ns/100ps
`default_nettype none
`include "hbap_cfg.svh"
module hbap_host #(
	parameter int AW = `HBAP_ADDR_W,
	parameter int DW = `HBAP_DATA_W
) (
	input  wire logic          clock,
	input  wire logic          rst_n,
	input  wire logic          clk_en,
	hbap_bus_if.host           bus,
	input  wire logic          mux_mode,
	input  wire logic          ds_style,
	input  wire logic          slow_arbitration,
	input  wire logic          timing_pin_level,
	input  wire logic          cmd_valid,
	input  wire logic          cmd_write,
	input  wire logic [AW-1:0] cmd_addr,
	input  wire logic [DW-1:0] cmd_wdata,
	output logic               cmd_ready,
	output logic               rsp_valid,
	output logic [DW-1:0]      rsp_rdata
);

	////////////////////////////////////////////////////////////////////
	// state record

	typedef struct packed {
		hbap_pkg::hbap_host_state_type st;
		logic          ale;
		logic          cs_n;
		logic          ds_n;
		logic          rd_n;
		logic          wr_n;
		logic          dir;
		logic          tpin;
		logic [AW-1:0] addr;
		logic [DW-1:0] dout;
		logic          doe;
		logic          wr;
		logic [DW-1:0] wdata;
		logic [4:0]    cnt;
		logic          rdy;
		logic          rv;
		logic [DW-1:0] rdata;
	} hbap_host_rec_type;

	hbap_host_rec_type s_q;
	hbap_host_rec_type s_d;
	logic [4:0]        gap_cyc;

	// doubled spacing after every strobe covers all gap limits
	assign gap_cyc = hbap_pkg::hbap_tarb_cycles(`HBAP_GAP_TARB,
		slow_arbitration);

	////////////////////////////////////////////////////////////////////
	// next state

	always_comb begin
		s_d = s_q;
		s_d.rv = 1'b0;
		s_d.tpin = timing_pin_level;
		case (s_q.st)
			hbap_pkg::HBAP_H_IDLE: begin
				if (cmd_valid && s_q.rdy) begin
					s_d.rdy = 1'b0;
					s_d.wr = cmd_write;
					s_d.wdata = cmd_wdata;
					s_d.cs_n = 1'b0;
					s_d.addr = cmd_addr;
					s_d.dir = ~cmd_write;
					if (mux_mode) begin
						s_d.ale = 1'b1;
						s_d.doe = 1'b1;
						s_d.dout = DW'(cmd_addr);
						s_d.st = hbap_pkg::HBAP_H_ADDR;
					end else begin
						s_d.st = hbap_pkg::HBAP_H_SETUP;
					end
				end
			end
			hbap_pkg::HBAP_H_ADDR: begin
				s_d.ale = 1'b0; // address still on the lines
				s_d.st = hbap_pkg::HBAP_H_SETUP;
			end
			hbap_pkg::HBAP_H_SETUP: begin
				// direction already stable one cycle before the strobe
				s_d.doe = s_q.wr;
				s_d.dout = s_q.wdata;
				s_d.ds_n = ~ds_style;
				s_d.rd_n = ds_style | s_q.wr;
				s_d.wr_n = ds_style | ~s_q.wr;
				s_d.cnt = 5'h00;
				s_d.st = hbap_pkg::HBAP_H_STROBE;
			end
			hbap_pkg::HBAP_H_STROBE: begin
				s_d.cnt = s_q.cnt + 5'h01;
				if (s_q.cnt == `HBAP_STROBE_CYC - 5'h01) begin
					s_d.ds_n = 1'b1;
					s_d.rd_n = 1'b1;
					s_d.wr_n = 1'b1;
					s_d.rv = ~s_q.wr;
					if (!s_q.wr)
						s_d.rdata = bus.data_bus;
					s_d.cnt = 5'h00;
					s_d.st = hbap_pkg::HBAP_H_GAP;
				end
			end
			hbap_pkg::HBAP_H_GAP: begin
				// data and select held one cycle past the strobe
				s_d.doe = 1'b0;
				s_d.cs_n = 1'b1;
				s_d.cnt = s_q.cnt + 5'h01;
				if (s_q.cnt == gap_cyc - 5'h01) begin
					s_d.rdy = 1'b1;
					s_d.st = hbap_pkg::HBAP_H_IDLE;
				end
			end
			default: begin
				s_d.st = hbap_pkg::HBAP_H_IDLE;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////
	// state register, frozen while the clock enable is low

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			s_q <= '0;
			s_q.st <= hbap_pkg::HBAP_H_IDLE;
			s_q.cs_n <= 1'b1;
			s_q.ds_n <= 1'b1;
			s_q.rd_n <= 1'b1;
			s_q.wr_n <= 1'b1;
			s_q.dir <= 1'b1;
			s_q.tpin <= 1'b1;
			s_q.rdy <= 1'b1;
		end else if (clk_en) begin
			s_q <= s_d;
		end
	end

	////////////////////////////////////////////////////////////////////
	// outputs straight from the state record

	assign bus.ale                   = s_q.ale;
	assign bus.chip_select_n         = s_q.cs_n;
	assign bus.data_strobe_n         = s_q.ds_n;
	assign bus.read_strobe_n         = s_q.rd_n;
	assign bus.write_strobe_n        = s_q.wr_n;
	assign bus.direction             = s_q.dir;
	assign bus.bus_timing_select_pin = s_q.tpin;
	assign bus.addr                  = s_q.addr;
	assign bus.host_data_o           = s_q.dout;
	assign bus.host_data_oe          = s_q.doe;
	assign cmd_ready                 = s_q.rdy;
	assign rsp_valid                 = s_q.rv;
	assign rsp_rdata                 = s_q.rdata;

endmodule // hbap_host
`default_nettype wire

// file: tb/hbap_chk.sv
// assertion checker watching the parallel bus between host and device ends
`timescale 1ns/100ps
`default_nettype none
module hbap_chk #(
	parameter int AW = 3,
	parameter int DW = 8
) (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic ale,
	input wire logic chip_select_n,
	input wire logic data_strobe_n,
	input wire logic read_strobe_n,
	input wire logic write_strobe_n,
	input wire logic direction,
	input wire logic host_data_oe,
	input wire logic dev_data_oe
);
	////////////////////////////////////////////////////////////////////////
	// any strobe of either control style active
	logic act;
	assign act = !(data_strobe_n && read_strobe_n && write_strobe_n);

	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);

	////////////////////////////////////////////////////////////////////////
	// data line ownership
	a_single_driver: assert property (!(dev_data_oe && host_data_oe))
		else $error("both ends drive the data lines");
	a_drive_on_read: assert property ($rose(dev_data_oe) |->
		!read_strobe_n || (!data_strobe_n && direction))
		else $error("device drive starts outside a read strobe");
	a_release_idle: assert property (!act [*4] |-> !dev_data_oe)
		else $error("device still drives with strobes idle");
	a_no_write_drive: assert property ((!write_strobe_n ||
		(!data_strobe_n && !direction)) |-> !dev_data_oe)
		else $error("device drives during a write");

	////////////////////////////////////////////////////////////////////////
	// strobe spacing and shape kept by the host end
	a_lead_spacing: assert property ($rose(act) |=> !$rose(act) [*7])
		else $error("strobe leading edges too close");
	a_tail_gap: assert property ($fell(act) |=> !act [*8])
		else $error("next strobe too soon after strobe end");
	a_strobe_width: assert property ($rose(act) |-> act [*6] ##1 !act)
		else $error("strobe width is not six cycles");
	a_dir_hold: assert property ((!data_strobe_n || $rose(data_strobe_n))
		|-> $stable(direction))
		else $error("direction moved around the data strobe");
	a_cs_strobe: assert property (act |-> !chip_select_n)
		else $error("strobe without chip select");
	a_ale_order: assert property ($rose(ale) |->
		(!chip_select_n && host_data_oe) ##1 (!ale && !chip_select_n) ##1 act)
		else $error("address phase order broken");

	// main scenarios seen
	c_read_drive: cover property ($rose(dev_data_oe));
	c_wr_strobe: cover property ($fell(write_strobe_n));
	c_ds_read: cover property ($fell(data_strobe_n) && direction);
	c_addr_phase: cover property ($rose(ale));
endmodule // hbap_chk
`default_nettype wire

// file: tb/testbench.sv
// self-checking bench joining host and device ends over the parallel bus
`timescale 1ns/100ps
`default_nettype none
module testbench;
	logic       clock, rst_n, mux, ds, slow, tbit, pin;
	logic       cmd_valid, cmd_write, cmd_ready, rsp_valid;
	logic [2:0] cmd_addr, acc_addr;
	logic [7:0] cmd_wdata, rsp_rdata, core_q, acc_wdata;
	logic       acc_req, acc_write, fault, case_one, acc2_req, fault2;
	int         failures, num_checks, cycles, acc2_n;

	hbap_bus_if bus ();
	hbap_bus_if bus2 ();

	////////////////////////////////////////////////////////////////////////
	// the two ends, plus a second device end facing the bench driver
	hbap_host hbap_host_i (.clock(clock), .rst_n(rst_n), .clk_en(1'b1),
		.bus(bus), .mux_mode(mux), .ds_style(ds), .slow_arbitration(slow),
		.timing_pin_level(pin), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
		.cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .cmd_ready(cmd_ready),
		.rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata));
	hbap_device hbap_device_i (.clock(clock), .rst_n(rst_n), .clk_en(1'b1),
		.bus(bus), .mux_mode(mux), .ds_style(ds), .slow_arbitration(slow),
		.bus_timing_select_bit(tbit), .acc_rdata(core_q), .acc_req(acc_req),
		.acc_write(acc_write), .acc_addr(acc_addr), .acc_wdata(acc_wdata),
		.spacing_fault(fault), .timing_case_one(case_one));
	hbap_device hbap_device_i2 (.clock(clock), .rst_n(rst_n), .clk_en(1'b1),
		.bus(bus2), .mux_mode(mux), .ds_style(ds), .slow_arbitration(slow),
		.bus_timing_select_bit(tbit), .acc_rdata(core_q), .acc_req(acc2_req),
		.acc_write(), .acc_addr(), .acc_wdata(), .spacing_fault(fault2),
		.timing_case_one());
	hbap_chk #(.AW(3), .DW(8)) hbap_chk_i (.clock(clock), .rst_n(rst_n),
		.ale(bus.ale), .chip_select_n(bus.chip_select_n),
		.data_strobe_n(bus.data_strobe_n), .read_strobe_n(bus.read_strobe_n),
		.write_strobe_n(bus.write_strobe_n), .direction(bus.direction),
		.host_data_oe(bus.host_data_oe), .dev_data_oe(bus.dev_data_oe));

	initial begin
		clock = 0;
		forever #10 clock = ~clock;
	end

	// core stand-in keeps the last byte written; counts and watchdog
	always @(posedge clock) begin
		if (acc_req && acc_write) core_q <= acc_wdata;
		if (acc2_req) acc2_n++;
		cycles++;
		if (cycles == 20000) begin
			failures++;
			print_verdict();
		end
	end

	////////////////////////////////////////////////////////////////////////
	// shared tasks
	task automatic print_verdict();
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task automatic check(input string name, input logic [7:0] seen, exp);
		num_checks++;
		if (seen !== exp) begin
			failures++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask

	// bounded wait for the host to accept commands again
	task automatic wait_ready();
		int n;
		n = 0;
		while (cmd_ready !== 1'b1 && n < 100) begin
			tick(1);
			n++;
		end
		if (n == 100) failures++;
	endtask

	task automatic do_cmd(input logic w, input logic [2:0] a,
		input logic [7:0] d, output logic [7:0] q);
		int n;
		wait_ready();
		cmd_valid = 1;
		cmd_write = w;
		cmd_addr = a;
		cmd_wdata = d;
		tick(1);
		cmd_valid = 0;
		n = 0;
		q = 8'h00;
		while (!w && rsp_valid !== 1'b1 && n < 40) begin
			tick(1);
			n++;
		end
		if (n == 40) failures++;
		if (!w) q = rsp_rdata;
		tick(1);
		wait_ready();
	endtask

	// bench-driven read strobe on the second bus, three cycles low and high
	task automatic strobe2();
		bus2.read_strobe_n = 0;
		tick(3);
		bus2.read_strobe_n = 1;
		tick(3);
	endtask

	////////////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		logic [7:0] q, d;
		rst_n = 0;
		{tbit, slow, ds, mux} = 4'h0;
		pin = 1;
		cmd_valid = 0;
		cmd_write = 0;
		cmd_addr = 3'h0;
		cmd_wdata = 8'h00;
		core_q = 8'h00;
		failures = 0;
		num_checks = 0;
		cycles = 0;
		acc2_n = 0;
		{bus2.ale, bus2.direction, bus2.host_data_oe} = 3'b010;
		{bus2.data_strobe_n, bus2.write_strobe_n} = 2'b11;
		{bus2.read_strobe_n, bus2.chip_select_n} = 2'b10;
		bus2.bus_timing_select_pin = 1;
		bus2.addr = 3'h4;
		bus2.host_data_o = 8'h00;
		// leading edges six cycles apart: legal at one clock a period only
		for (int s = 0; s < 2; s++) begin
			slow = s[0];
			rst_n = 0;
			tick(2);
			rst_n = 1;
			acc2_n = 0;
			strobe2();
			strobe2();
			tick(12);
			check("spacing fault", {7'h00, fault2}, {7'h00, s[0]});
			check("accesses", acc2_n[7:0], 8'(2 - s));
			$display("refusal test done, slow %0d", s);
		end
		// pointer read three cycles after a data read ends is refused
		slow = 0;
		rst_n = 0;
		tick(2);
		rst_n = 1;
		acc2_n = 0;
		strobe2();
		bus2.addr = 3'h3;
		strobe2();
		tick(12);
		check("data gap fault", {7'h00, fault2}, 8'h01);
		check("data gap accesses", acc2_n[7:0], 8'h01);
		bus2.addr = 3'h4;
		$display("data gap refusal test done");
		// every bus mode, control style, speed and timing selection
		for (int i = 0; i < 16; i++) begin
			{tbit, slow, ds, mux} = i[3:0];
			pin = i[0] ^ i[2];
			d = {i[3:0], 4'h5};
			tick(3);
			check("case one", {7'h00, case_one}, {7'h00, ~tbit & pin});
			do_cmd(1, 3'h4, d, q);
			check("write addr", {5'h00, acc_addr}, 8'h04);
			check("write data", acc_wdata, d);
			check("write flag", {7'h00, acc_write}, 8'h01);
			do_cmd(0, 3'h3, 8'h00, q);
			check("read after write", q, d);
			do_cmd(1, 3'h3, ~d, q);
			check("ptr low addr", {5'h00, acc_addr}, 8'h03);
			do_cmd(0, 3'h4, 8'h00, q);
			check("read after ptr", q, ~d);
			check("no fault", {7'h00, fault}, 8'h00);
			$display("mode test %0d done", i);
		end
		print_verdict();
	end
endmodule // testbench
`default_nettype wire
